//--- rtl/sfr_bank_pkg.sv
// Constants shared by the paged register bank and its storage array
package sfr_bank_pkg;

   // Register word indices; byte address is four times the index
   localparam int             IDX_W           = 8;
   localparam logic [7:0]     BANK_SELECT_IDX = 8'hA3;
   localparam logic [7:0]     REMAP_IDX       = 8'h80;

   // Shared (paged) index windows
   localparam logic [7:0]     SHARED_A_LO     = 8'h9A;
   localparam logic [7:0]     SHARED_A_HI     = 8'h9F;
   localparam logic [7:0]     SHARED_B_LO     = 8'hA4;
   localparam logic [7:0]     SHARED_B_HI     = 8'hA7;
   localparam logic [7:0]     SHARED_C_LO     = 8'hFA;
   localparam logic [7:0]     SHARED_C_HI     = 8'hFF;
   localparam logic [3:0]     SHARED_B_BASE   = 4'h6;
   localparam logic [3:0]     SHARED_C_BASE   = 4'hA;
   localparam int             SHARED_COUNT    = 16;
   localparam int             PAGE_COUNT      = 4;
   localparam int             SFR_W           = 8;

   // Bank select field layout
   localparam int             PAGE_LSB        = 0;
   localparam int             PAGE_W          = 3;
   localparam int             SLOT_LSB        = 4;
   localparam int             SLOT_W          = 2;
   localparam int             ACT_LSB         = 6;
   localparam int             ACT_W           = 2;
   localparam int             SLOT_COUNT      = 3;
   localparam logic [7:0]     BANK_RESET      = 8'h00;
   localparam logic [2:0]     PAGE_RESET      = 3'h0;

   // Action codes
   localparam logic [1:0]     ACT_SAVE        = 2'h2;
   localparam logic [1:0]     ACT_RESTORE     = 2'h3;

   // Remap register
   localparam int             REMAP_BIT       = 0;

   // AXI responses
   localparam logic [1:0]     RESP_OKAY       = 2'h0;
   localparam logic [1:0]     RESP_SLVERR     = 2'h2;

endpackage

//--- rtl/paged_sfr_store.sv
// Flip-flop storage for the paged registers, one word per page and slot
`timescale 1ns/1ps
module paged_sfr_store #(
   parameter int PAGES = 4,
   parameter int SLOTS = 16,
   parameter int W     = 8
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Write port
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(PAGES)-1:0] wr_page_i,
   input  wire logic [$clog2(SLOTS)-1:0] wr_slot_i,
   input  wire logic [W-1:0]             wr_data_i,
   // Read port, combinational
   input  wire logic [$clog2(PAGES)-1:0] rd_page_i,
   input  wire logic [$clog2(SLOTS)-1:0] rd_slot_i,
   output logic      [W-1:0]             rd_data_o
);
   localparam int PW = $clog2(PAGES);

   logic [W-1:0] mem_reg  [PAGES*SLOTS];
   logic [W-1:0] mem_next [PAGES*SLOTS];

   // page and slot form the index
   always_comb begin
      for (int i = 0; i < PAGES*SLOTS; i++) begin
         mem_next[i] = mem_reg[i];
      end
      if (wr_en_i) begin
         mem_next[{wr_page_i, wr_slot_i}] = wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      for (int i = 0; i < PAGES*SLOTS; i++) begin
         if (rst_i) begin
            mem_reg[i] <= '0;
         end else begin
            mem_reg[i] <= mem_next[i];
         end
      end
   end

   assign rd_data_o = mem_reg[{rd_page_i, rd_slot_i}];

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [PW-1:0] other_page;
   assign other_page = PW'(wr_page_i + 1'b1);

   chk_store_write_lands: assert property (
      wr_en_i |=> mem_reg[{$past(wr_page_i), $past(wr_slot_i)}] == $past(wr_data_i))
      else $error("paged word not written");
   chk_store_pages_apart: assert property (
      wr_en_i |=> mem_reg[{$past(other_page), $past(wr_slot_i)}]
                  == $past(mem_reg[{other_page, wr_slot_i}]))
      else $error("write leaked into another page");
endmodule // paged_sfr_store

//--- rtl/paged_sfr_bank_select.sv
// Bank select register and page decode for the shared timer unit registers
// Functional notes
// - Action codes 00 and 01 load the written page directly and ignore the slot number.
// - Reading the page field returns the page now used to decode the shared addresses.
// - Action 10 saves the old page into the chosen slot and makes the written page active.
// - Action 11 ignores the written page and restores the active page from the chosen slot.
// - Slot number 00, 01 and 10 select saved slot zero, one and two.
// - Bit 3 reads as zero and software writes it as zero.
// - Each of the sixteen shared addresses reaches one of four registers picked by page 0 to 3.
// - The bank select register sits at index A3 of the standard area, remap bit clear.
//
// The AXI4-Lite slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module paged_sfr_bank_select #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   // AXI4-Lite write channels
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   // AXI4-Lite read channels
   input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   // Paging state to the rest of the unit
   output logic [2:0]             active_page_o,
   output logic                   sfr_remap_select_o
);
   localparam int PG_W = $clog2(sfr_bank_pkg::PAGE_COUNT);
   localparam int SL_W = $clog2(sfr_bank_pkg::SHARED_COUNT);
   typedef enum logic {WR_COLLECT, WR_RESP} wr_state_t;
   typedef enum logic {RD_IDLE, RD_DATA} rd_state_t;
   // Word index of a byte address; bit 8 flags an aligned, in-range address
   function automatic logic [8:0] word_index(input logic [ADDR_W-1:0] a);
      logic ok;
      ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:sfr_bank_pkg::IDX_W+2] == '0);
      return {ok, a[sfr_bank_pkg::IDX_W+1:2]};
   endfunction
   // Shared slot of an index; bit 4 flags a hit, offsets cut to slot width
   function automatic logic [4:0] shared_decode(input logic [7:0] idx);
      if (idx >= sfr_bank_pkg::SHARED_A_LO && idx <= sfr_bank_pkg::SHARED_A_HI)
         return {1'b1, 4'(idx - sfr_bank_pkg::SHARED_A_LO)};
      if (idx >= sfr_bank_pkg::SHARED_B_LO && idx <= sfr_bank_pkg::SHARED_B_HI)
         return {1'b1, 4'(4'(idx - sfr_bank_pkg::SHARED_B_LO) + sfr_bank_pkg::SHARED_B_BASE)};
      if (idx >= sfr_bank_pkg::SHARED_C_LO && idx <= sfr_bank_pkg::SHARED_C_HI)
         return {1'b1, 4'(4'(idx - sfr_bank_pkg::SHARED_C_LO) + sfr_bank_pkg::SHARED_C_BASE)};
      return 5'h00;
   endfunction

   // Write channel state
   wr_state_t         wr_state_reg, wr_state_next;
   logic              aw_got_reg, aw_got_next;
   logic              w_got_reg, w_got_next;
   logic [ADDR_W-1:0] waddr_reg, waddr_next;
   logic [7:0]        wdata_reg, wdata_next;
   logic              wstrb_reg, wstrb_next;
   logic              awready_reg, awready_next;
   logic              wready_reg, wready_next;
   logic              bvalid_reg, bvalid_next;
   logic [1:0]        bresp_reg, bresp_next;
   // Read channel state
   rd_state_t         rd_state_reg, rd_state_next;
   logic              arready_reg, arready_next;
   logic              rvalid_reg, rvalid_next;
   logic [31:0]       rdata_reg, rdata_next;
   logic [1:0]        rresp_reg, rresp_next;
   logic              rd_bank_reg, rd_bank_next;
   // Paging state
   logic [2:0]        page_reg, page_next;
   logic [2:0]        slot_reg  [sfr_bank_pkg::SLOT_COUNT];
   logic [2:0]        slot_next [sfr_bank_pkg::SLOT_COUNT];
   logic              remap_reg, remap_next;
   // Decode of the held write and of the offered read
   logic [8:0]        w_idx, r_idx;
   logic [4:0]        w_sh, r_sh;
   logic              wr_do, page_ok;
   logic              w_bank, w_shared, w_remap;
   logic              r_bank, r_shared, r_remap;
   logic              bank_wr, store_wr;
   logic [1:0]        act;
   logic [1:0]        slot_sel;
   logic [2:0]        new_page;
   logic [7:0]        store_rdata;
   assign w_idx    = word_index(waddr_reg);
   assign r_idx    = word_index(s_axi_araddr_i);
   assign w_sh     = shared_decode(w_idx[7:0]);
   assign r_sh     = shared_decode(r_idx[7:0]);
   assign page_ok  = (page_reg < 3'(sfr_bank_pkg::PAGE_COUNT));
   assign wr_do    = (wr_state_reg == WR_COLLECT) && aw_got_reg && w_got_reg;
   // bank select only in the standard area
   assign w_bank   = w_idx[8] && (w_idx[7:0] == sfr_bank_pkg::BANK_SELECT_IDX) && !remap_reg;
   assign w_shared = w_idx[8] && w_sh[4] && !remap_reg && page_ok;
   assign w_remap  = w_idx[8] && (w_idx[7:0] == sfr_bank_pkg::REMAP_IDX);
   assign r_bank   = r_idx[8] && (r_idx[7:0] == sfr_bank_pkg::BANK_SELECT_IDX) && !remap_reg;
   assign r_shared = r_idx[8] && r_sh[4] && !remap_reg && page_ok;
   assign r_remap  = r_idx[8] && (r_idx[7:0] == sfr_bank_pkg::REMAP_IDX);
   assign bank_wr  = wr_do && w_bank && wstrb_reg;
   assign store_wr = wr_do && w_shared && wstrb_reg;
   assign act      = wdata_reg[sfr_bank_pkg::ACT_LSB +: sfr_bank_pkg::ACT_W];
   assign slot_sel = wdata_reg[sfr_bank_pkg::SLOT_LSB +: sfr_bank_pkg::SLOT_W];
   assign new_page = wdata_reg[sfr_bank_pkg::PAGE_LSB +: sfr_bank_pkg::PAGE_W];
   // active page picks one of four words per shared address
   paged_sfr_store #(
      .PAGES (sfr_bank_pkg::PAGE_COUNT),
      .SLOTS (sfr_bank_pkg::SHARED_COUNT),
      .W     (sfr_bank_pkg::SFR_W)
   ) u_store (
      .clk_i     (clk_i),
      .rst_i     (rst_i),
      .wr_en_i   (store_wr),
      .wr_page_i (page_reg[PG_W-1:0]),
      .wr_slot_i (w_sh[SL_W-1:0]),
      .wr_data_i (wdata_reg),
      .rd_page_i (page_reg[PG_W-1:0]),
      .rd_slot_i (r_sh[SL_W-1:0]),
      .rd_data_o (store_rdata)
   );
   // Address and data are taken in either order, then executed together
   always_comb begin
      wr_state_next = wr_state_reg;
      aw_got_next   = aw_got_reg;
      w_got_next    = w_got_reg;
      waddr_next    = waddr_reg;
      wdata_next    = wdata_reg;
      wstrb_next    = wstrb_reg;
      bvalid_next   = bvalid_reg;
      bresp_next    = bresp_reg;
      if (s_axi_awvalid_i && awready_reg) begin
         aw_got_next = 1'b1;
         waddr_next  = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         w_got_next = 1'b1;
         wdata_next = s_axi_wdata_i[7:0];
         wstrb_next = s_axi_wstrb_i[0];
      end
      case (wr_state_reg)
         WR_COLLECT: begin
            if (wr_do) begin
               aw_got_next   = 1'b0;
               w_got_next    = 1'b0;
               bvalid_next   = 1'b1;
               bresp_next    = (w_bank || w_shared || w_remap) ?
                               sfr_bank_pkg::RESP_OKAY : sfr_bank_pkg::RESP_SLVERR;
               wr_state_next = WR_RESP;
            end
         end
         WR_RESP: begin
            if (s_axi_bready_i) begin
               bvalid_next   = 1'b0;
               wr_state_next = WR_COLLECT;
            end
         end
         default: wr_state_next = WR_COLLECT;
      endcase
      awready_next = (wr_state_next == WR_COLLECT) && !aw_got_next;
      wready_next  = (wr_state_next == WR_COLLECT) && !w_got_next;
   end

   // Page change on a bank select write; remap bit change on a remap write
   always_comb begin
      page_next  = page_reg;
      remap_next = remap_reg;
      slot_next  = slot_reg;
      if (wr_do && w_remap && wstrb_reg) begin
         remap_next = wdata_reg[sfr_bank_pkg::REMAP_BIT];
      end
      if (bank_wr) begin
         case (act)
            // save old page, load the new one
            sfr_bank_pkg::ACT_SAVE: begin
               // slot number picks the target slot
               if (slot_sel < 2'(sfr_bank_pkg::SLOT_COUNT)) begin
                  slot_next[slot_sel] = page_reg;
               end
               page_next = new_page;
            end
            // written page is dropped; slot 11 has no slot and keeps the page
            sfr_bank_pkg::ACT_RESTORE: begin
               if (slot_sel < 2'(sfr_bank_pkg::SLOT_COUNT)) begin
                  page_next = slot_reg[slot_sel];
               end
            end
            // manual mode ignores the slot number
            default: page_next = new_page;
         endcase
      end
   end

   // One read at a time; data is captured at the address handshake
   always_comb begin
      rd_state_next = rd_state_reg;
      rvalid_next   = rvalid_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      rd_bank_next  = rd_bank_reg;
      case (rd_state_reg)
         RD_IDLE: begin
            if (s_axi_arvalid_i && arready_reg) begin
               rvalid_next   = 1'b1;
               rd_bank_next  = r_bank;
               rd_state_next = RD_DATA;
               rresp_next    = (r_bank || r_shared || r_remap) ?
                               sfr_bank_pkg::RESP_OKAY : sfr_bank_pkg::RESP_SLVERR;
               rdata_next    = 32'h0000_0000;
               // page only; write-only and reserved bits read zero
               if (r_bank) begin
                  rdata_next[sfr_bank_pkg::PAGE_LSB +: sfr_bank_pkg::PAGE_W] = page_reg;
               end else if (r_shared) begin
                  rdata_next[7:0] = store_rdata;
               end else if (r_remap) begin
                  rdata_next[sfr_bank_pkg::REMAP_BIT] = remap_reg;
               end
            end
         end
         RD_DATA: begin
            if (s_axi_rready_i) begin
               rvalid_next   = 1'b0;
               rd_state_next = RD_IDLE;
            end
         end
         default: rd_state_next = RD_IDLE;
      endcase
      arready_next = (rd_state_next == RD_IDLE);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_state_reg <= WR_COLLECT;
         aw_got_reg   <= 1'b0;
         w_got_reg    <= 1'b0;
         waddr_reg    <= '0;
         wdata_reg    <= sfr_bank_pkg::BANK_RESET;
         wstrb_reg    <= 1'b0;
         awready_reg  <= 1'b0;
         wready_reg   <= 1'b0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= sfr_bank_pkg::RESP_OKAY;
         rd_state_reg <= RD_IDLE;
         arready_reg  <= 1'b0;
         rvalid_reg   <= 1'b0;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= sfr_bank_pkg::RESP_OKAY;
         rd_bank_reg  <= 1'b0;
         remap_reg    <= 1'b0;
         page_reg     <= sfr_bank_pkg::PAGE_RESET;
         slot_reg     <= '{default: sfr_bank_pkg::PAGE_RESET};
      end else begin
         wr_state_reg <= wr_state_next;
         aw_got_reg   <= aw_got_next;
         w_got_reg    <= w_got_next;
         waddr_reg    <= waddr_next;
         wdata_reg    <= wdata_next;
         wstrb_reg    <= wstrb_next;
         awready_reg  <= awready_next;
         wready_reg   <= wready_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         rd_state_reg <= rd_state_next;
         arready_reg  <= arready_next;
         rvalid_reg   <= rvalid_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
         rd_bank_reg  <= rd_bank_next;
         remap_reg    <= remap_next;
         page_reg     <= page_next;
         slot_reg     <= slot_next;
      end
   end

   assign s_axi_awready_o    = awready_reg;
   assign s_axi_wready_o     = wready_reg;
   assign s_axi_bvalid_o     = bvalid_reg;
   assign s_axi_bresp_o      = bresp_reg;
   assign s_axi_arready_o    = arready_reg;
   assign s_axi_rvalid_o     = rvalid_reg;
   assign s_axi_rdata_o      = rdata_reg;
   assign s_axi_rresp_o      = rresp_reg;
   assign active_page_o      = page_reg;
   assign sfr_remap_select_o = remap_reg;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_manual_load: assert property (
      bank_wr && !act[1] |=> page_reg == $past(new_page))
      else $error("manual page not loaded");
   chk_page_readback: assert property (
      s_axi_arvalid_i && arready_reg && r_bank |=> rvalid_reg && rd_bank_reg
         && rdata_reg[2:0] == $past(page_reg))
      else $error("page readback wrong");
   chk_save_switch: assert property (
      bank_wr && act == sfr_bank_pkg::ACT_SAVE && slot_sel != 2'h3
      |=> slot_reg[$past(slot_sel)] == $past(page_reg) && page_reg == $past(new_page))
      else $error("save and switch failed");
   chk_restore_page: assert property (
      bank_wr && act == sfr_bank_pkg::ACT_RESTORE && slot_sel != 2'h3
      |=> page_reg == $past(slot_reg[slot_sel]))
      else $error("restore failed");
   chk_slot_isolation: assert property (
      bank_wr && act == sfr_bank_pkg::ACT_SAVE && slot_sel == 2'h0
      |=> $stable(slot_reg[1]) && $stable(slot_reg[2]))
      else $error("wrong slot touched");
   chk_reserved_zero: assert property (
      rvalid_reg && rd_bank_reg |-> rdata_reg[31:3] == 29'h0)
      else $error("reserved bits not zero");
   chk_remap_hides: assert property (
      wr_do && w_idx[8] && w_idx[7:0] == sfr_bank_pkg::BANK_SELECT_IDX && remap_reg
      |=> bresp_reg == sfr_bank_pkg::RESP_SLVERR && $stable(page_reg))
      else $error("bank select reachable while remapped");
   chk_reset_clear: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> page_reg == 3'h0 && slot_reg[0] == 3'h0 && slot_reg[1] == 3'h0
         && slot_reg[2] == 3'h0)
      else $error("reset did not clear paging");
   chk_write_answer: assert property (
      s_axi_awvalid_i && awready_reg && s_axi_wvalid_i && wready_reg ##1 1'b1
      |-> ##1 bvalid_reg)
      else $error("write response late");
   cov_save: cover property (bank_wr && act == sfr_bank_pkg::ACT_SAVE);
   cov_restore: cover property (bank_wr && act == sfr_bank_pkg::ACT_RESTORE);
   cov_shared_write: cover property (store_wr && page_reg == 3'h3);
   cov_shared_read: cover property (s_axi_arvalid_i && arready_reg && r_shared);
endmodule // paged_sfr_bank_select

//--- tb/sfr_cpu_model.sv
// Register bus master standing in for the processor
`timescale 1ns/1ps
module sfr_cpu_model (
   // Clock
   input  wire logic        clk_i,
   // Write channels
   output logic [11:0]      awaddr_o,
   output logic             awvalid_o,
   input  wire logic        awready_i,
   output logic [31:0]      wdata_o,
   output logic [3:0]       wstrb_o,
   output logic             wvalid_o,
   input  wire logic        wready_i,
   input  wire logic [1:0]  bresp_i,
   input  wire logic        bvalid_i,
   output logic             bready_o,
   // Read channels
   output logic [11:0]      araddr_o,
   output logic             arvalid_o,
   input  wire logic        arready_i,
   input  wire logic [31:0] rdata_i,
   input  wire logic [1:0]  rresp_i,
   input  wire logic        rvalid_i,
   output logic             rready_o
);
   initial begin
      {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
      {araddr_o, arvalid_o, rready_o} = '0;
   end

   // Released payload is scrambled so stale values never look valid
   task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge clk_i);
      awaddr_o <= a;
      awvalid_o <= 1'b1;
      wdata_o <= d;
      wstrb_o <= 4'hF;
      wvalid_o <= 1'b1;
      bready_o <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_i);
         if (awvalid_o && awready_i) begin
            aw_done = 1'b1;
            awvalid_o <= 1'b0;
            awaddr_o <= ~a;
         end
         if (wvalid_o && wready_i) begin
            w_done = 1'b1;
            wvalid_o <= 1'b0;
            wdata_o <= ~d;
         end
      end
      do @(posedge clk_i); while (bvalid_i !== 1'b1);
      r = bresp_i;
      bready_o <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_i);
      araddr_o <= a;
      arvalid_o <= 1'b1;
      rready_o <= 1'b1;
      do @(posedge clk_i); while (arready_i !== 1'b1);
      arvalid_o <= 1'b0;
      araddr_o <= ~a;
      while (rvalid_i !== 1'b1) @(posedge clk_i);
      d = rdata_i;
      r = rresp_i;
      rready_o <= 1'b0;
   endtask
endmodule // sfr_cpu_model

//--- tb/paged_sfr_bank_select_test.sv
// Self-checking bench for the paged register bank select
`timescale 1ns/1ps
module paged_sfr_bank_select_test;
   localparam logic [11:0] BANK_ADDR  = 12'h28C;
   localparam logic [11:0] REMAP_ADDR = 12'h200;
   localparam logic [1:0]  OK = 2'h0;
   localparam logic [1:0]  ERR = 2'h2;

   logic clk_i, rst_i;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, resp;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, remap;
   logic [2:0]  page;
   logic [31:0] d;
   int          errors, n_checks;

   paged_sfr_bank_select #(.ADDR_W(12)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .active_page_o(page),
      .sfr_remap_select_o(remap));

   sfr_cpu_model i_cpu (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
      .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
      .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
      .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
      .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task summarize();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Byte address is four times the register index
   function automatic logic [11:0] sh_addr(input int k);
      logic [7:0] idx;
      if (k < 6) idx = sfr_bank_pkg::SHARED_A_LO + 8'(k);
      else if (k < 10) idx = sfr_bank_pkg::SHARED_B_LO + 8'(k - 6);
      else idx = sfr_bank_pkg::SHARED_C_LO + 8'(k - 10);
      return {2'b00, idx, 2'b00};
   endfunction

   // Bit 3 always written as zero by software
   task bank(input logic [7:0] v, input logic [2:0] pg);
      i_cpu.wr(BANK_ADDR, {24'h0, v & 8'hF7}, resp);
      chk("bank write resp", {30'h0, OK}, {30'h0, resp});
      i_cpu.rd(BANK_ADDR, d, resp);
      chk("bank readback", {29'h0, pg}, d);
      chk("active page", {29'h0, pg}, {29'h0, page});
   endtask

   task test_reset();
      i_cpu.rd(BANK_ADDR, d, resp);
      chk("page after reset", 32'h0, d);
      bank(8'h00, 3'd0);
      i_cpu.rd(sh_addr(15), d, resp);
      chk("shared after reset", 32'h0, d);
      $display("test reset done");
   endtask

   task test_manual();
      for (int a = 0; a < 2; a++) begin
         bank({2'(a), 2'b10, 4'h5}, 3'd5);
         bank({2'(a), 2'b01, 4'h2}, 3'd2);
      end
      $display("test manual done");
   endtask

   // Slot code 11 saves nothing and restores nothing
   task test_save_restore();
      bank(8'h01, 3'd1);
      bank(8'h82, 3'd2);
      bank(8'h93, 3'd3);
      bank(8'hA0, 3'd0);
      bank(8'hD7, 3'd2);
      bank(8'hC6, 3'd1);
      bank(8'hE5, 3'd3);
      bank(8'hB1, 3'd1);
      bank(8'hF6, 3'd1);
      bank(8'hD0, 3'd2);
      $display("test save restore done");
   endtask

   task test_pages();
      for (int p = 0; p < 4; p++) begin
         bank({5'h0, 3'(p)}, 3'(p));
         for (int k = 0; k < 16; k++) begin
            i_cpu.wr(sh_addr(k), {24'h0, 2'b00, 2'(p), 4'(k)}, resp);
            chk("shared write resp", {30'h0, OK}, {30'h0, resp});
         end
      end
      for (int p = 0; p < 4; p++) begin
         bank({5'h0, 3'(p)}, 3'(p));
         for (int k = 0; k < 16; k++) begin
            i_cpu.rd(sh_addr(k), d, resp);
            chk("shared data", {24'h0, 2'b00, 2'(p), 4'(k)}, d);
         end
      end
      $display("test pages done");
   endtask

   task test_errors();
      bank(8'h04, 3'd4);
      i_cpu.rd(sh_addr(0), d, resp);
      chk("page 4 shared resp", {30'h0, ERR}, {30'h0, resp});
      i_cpu.rd(12'h004, d, resp);
      chk("unmapped resp", {30'h0, ERR}, {30'h0, resp});
      i_cpu.wr(REMAP_ADDR, 32'h1, resp);
      chk("remap out", 32'h1, {31'h0, remap});
      i_cpu.rd(BANK_ADDR, d, resp);
      chk("remapped bank resp", {30'h0, ERR}, {30'h0, resp});
      i_cpu.wr(BANK_ADDR, 32'h1, resp);
      chk("remapped bank write resp", {30'h0, ERR}, {30'h0, resp});
      chk("page kept", 32'h4, {29'h0, page});
      i_cpu.wr(REMAP_ADDR, 32'h0, resp);
      bank(8'h00, 3'd0);
      $display("test errors done");
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      $display("watchdog expired");
      summarize();
   end

   initial begin
      errors = 0;
      n_checks = 0;
      rst_i = 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      test_reset();
      test_manual();
      test_save_restore();
      test_pages();
      test_errors();
      summarize();
   end
endmodule // paged_sfr_bank_select_test
